// File: rtl/sram_rd_pkg.sv
// constants and types shared by the sram read port design
package sram_rd_pkg;

	localparam int DATA_W     = 18;
	localparam int FIFO_DEPTH = 4;
	localparam int CNT_W      = 3;

	// words per read burst
	localparam logic [CNT_W-1:0] BURST_LEN = 3'h4;

	// cycles after reset release before the clock-mode strap is caught
	localparam logic [1:0] STRAP_WAIT = 2'h3;

	// positions in the synchronised pin vector
	localparam int PIN_K_P   = 0;
	localparam int PIN_K_N   = 1;
	localparam int PIN_C_P   = 2;
	localparam int PIN_C_N   = 3;
	localparam int PIN_RPS_N = 4;
	localparam int PIN_DLL_N = 5;
	localparam int PIN_W     = 6;

	localparam logic [PIN_W-1:0]  PIN_RST  = 6'h3F;
	localparam logic [DATA_W-1:0] DATA_RST = 18'h00000;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_WAIT_K = 2'b01,
		ST_DRIVE  = 2'b10,
		ST_TAIL   = 2'b11
	} rd_state_e;

endpackage

// File: rtl/rd_stream_if.sv
// valid/ready word stream between the read port and its fifo
`timescale 1ns/100ps
interface rd_stream_if #(
	parameter int W = 18
);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// File: rtl/word_fifo.sv
// small word fifo with valid/ready on both sides
`timescale 1ns/100ps
module word_fifo #(
	parameter int W     = 18,
	parameter int DEPTH = 4
) (
	input  wire logic  i_sys_clk,
	input  wire logic  i_arst_n,
	rd_stream_if.snk   push,
	rd_stream_if.src   pop
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW:0]             wr;
		logic [AW:0]             rd;
	} fifo_s;

	fifo_s s_q;
	fifo_s s_d;
	logic  full;
	logic  empty;

	assign empty      = (s_q.wr == s_q.rd);
	assign full       = (s_q.wr[AW-1:0] == s_q.rd[AW-1:0]) && (s_q.wr[AW] != s_q.rd[AW]);
	assign push.ready = !full;
	assign pop.valid  = !empty;
	assign pop.data   = s_q.mem[s_q.rd[AW-1:0]];

	always_comb begin
		s_d = s_q;
		if (push.valid && !full) begin
			s_d.mem[s_q.wr[AW-1:0]] = push.data;
			s_d.wr = s_q.wr + {{AW{1'b0}}, 1'b1};
		end
		if (pop.ready && !empty) begin
			s_d.rd = s_q.rd + {{AW{1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
endmodule

// File: rtl/ddr_sram_read_port.sv
// read port, output clocking and echo clocks of a ddr sram
//
// Contract
// R1: words launched on output clock pair rises
// R2: data lines released whenever port deselected; code drives on to burst end and the next positive output rise
// R3: port select sampled at input strobe rise
// R4: deselect finishes burst, releases after output rise
// R5: burst length taken as four words
// R6: controller supplies complementary output clock pair
// R7: accesses begin on positive input strobe rise
// R8: negative input strobe rise launches in single mode
// R9: echo clocks follow output clock, free running
// R10: dll disable low adds launch delay
// R11: output clocks strapped high select single mode
// R12: lowest word first after next strobe rise
// R13: data released after power-up until read
`timescale 1ns/100ps
module ddr_sram_read_port
	import sram_rd_pkg::*;
(
	input  wire logic                       i_sys_clk,
	input  wire logic                       i_arst_n,
	input  wire logic                       i_input_strobe_pos,
	input  wire logic                       i_input_strobe_neg,
	input  wire logic                       i_outbound_timing_pos,
	input  wire logic                       i_outbound_timing_neg,
	input  wire logic                       i_read_port_select_n,
	input  wire logic                       i_dll_disable_n,
	input  wire logic                       i_core_valid,
	input  wire logic [sram_rd_pkg::DATA_W-1:0] i_core_data,
	output logic                            o_core_ready,
	output logic                            o_core_rd_req,
	output logic [sram_rd_pkg::DATA_W-1:0]  o_read_data,
	output logic                            o_read_data_oe,
	output logic                            o_echo_strobe_pos,
	output logic                            o_echo_strobe_neg,
	output logic                            o_single_clock_mode
);
	import sram_rd_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic [PIN_W-1:0]  s1;
		logic [PIN_W-1:0]  s2;
		logic [PIN_W-1:0]  prev;
		logic [1:0]        strap_cnt;
		logic              strap_done;
		logic              single;
		rd_state_e         st;
		logic [CNT_W-1:0]  cnt;
		logic              pend;
		logic [DATA_W-1:0] q;
		logic              oe;
		logic              req;
		logic              echo_p;
		logic              echo_n;
		logic              dly_any;
		logic              dly_pos;
	} port_s;

	port_s s_q;
	port_s s_d;

	logic [PIN_W-1:0] pins;
	logic [PIN_W-1:0] rise;
	logic             k_rise;
	logic             op_rise;
	logic             on_rise;
	logic             now_any;
	logic             launch;
	logic             launch_pos;
	logic             rd_start;
	logic             launch_ok;
	logic             pop_rdy;

	rd_stream_if #(.W(DATA_W)) in_if ();
	rd_stream_if #(.W(DATA_W)) out_if ();

	////////////////////////////////////////////////////////////////////////////////
	// fifo between core array and output register

	assign in_if.valid  = i_core_valid;
	assign in_if.data   = i_core_data;
	assign o_core_ready = in_if.ready;
	assign out_if.ready = pop_rdy;

	word_fifo #(
		.W     (DATA_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.i_sys_clk (i_sys_clk),
		.i_arst_n  (i_arst_n),
		.push      (in_if),
		.pop       (out_if)
	);

	////////////////////////////////////////////////////////////////////////////////
	// edge detection on synchronised pins

	assign pins = {i_dll_disable_n, i_read_port_select_n, i_outbound_timing_neg,
		i_outbound_timing_pos, i_input_strobe_neg, i_input_strobe_pos};

	assign rise     = s_q.s2 & ~s_q.prev;
	assign k_rise   = rise[PIN_K_P];                                         // R7
	assign op_rise  = s_q.single ? rise[PIN_K_P] : rise[PIN_C_P];            // R1
	assign on_rise  = s_q.single ? rise[PIN_K_N] : rise[PIN_C_N];            // R8
	assign now_any  = op_rise | on_rise;
	// with the dll off every launch slips one system cycle
	assign launch     = s_q.s2[PIN_DLL_N] ? now_any : s_q.dly_any;           // R10
	assign launch_pos = s_q.s2[PIN_DLL_N] ? op_rise : s_q.dly_pos;           // R10
	assign rd_start   = k_rise & ~s_q.s2[PIN_RPS_N];                         // R3
	// the lowest-order word of a burst always leaves on a positive output rise
	assign launch_ok  = launch & ((s_q.cnt != BURST_LEN) | launch_pos);   // R12
	assign pop_rdy    = (s_q.st == ST_DRIVE) && launch_ok;

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		s_d         = s_q;
		s_d.s1      = pins;
		s_d.s2      = s_q.s1;
		s_d.prev    = s_q.s2;
		s_d.req     = 1'b0;
		s_d.dly_any = now_any;
		s_d.dly_pos = op_rise;

		// strap caught once, after the synchronisers have filled
		if (!s_q.strap_done) begin
			if (s_q.strap_cnt == STRAP_WAIT) begin
				s_d.strap_done = 1'b1;
				s_d.single     = s_q.s2[PIN_C_P] & s_q.s2[PIN_C_N];       // R11
			end else begin
				s_d.strap_cnt = s_q.strap_cnt + 2'h1;
			end
		end

		// echo clocks track the active output clock without pause
		s_d.echo_p = s_q.single ? s_q.s2[PIN_K_P] : s_q.s2[PIN_C_P];      // R9
		s_d.echo_n = ~s_d.echo_p;                                         // R9

		unique case (s_q.st)
			ST_IDLE: begin
				if (rd_start) begin
					s_d.st   = ST_WAIT_K;
					s_d.req  = 1'b1;
					s_d.cnt  = BURST_LEN;                                 // R5
				end
			end
			ST_WAIT_K: begin
				if (launch_pos) begin
					s_d.oe = 1'b0;
				end
				if (rd_start) begin
					s_d.pend = 1'b1;
				end
				if (k_rise) begin
					s_d.st = ST_DRIVE;                                    // R12
				end
			end
			ST_DRIVE: begin
				if (rd_start) begin
					s_d.pend = 1'b1;
				end
				if (launch_ok && out_if.valid) begin
					s_d.q   = out_if.data;                                // R1
					s_d.oe  = 1'b1;
					s_d.cnt = CNT_W'(s_q.cnt - 3'h1);
					if (s_q.cnt == 3'h1) begin
						if (s_q.pend || rd_start) begin
							// back-to-back read continues seamlessly
							// a request seen in this same cycle stays pending only if an earlier one was already pending
							s_d.pend = s_q.pend & rd_start;
							s_d.req  = 1'b1;
							s_d.cnt  = BURST_LEN;                         // R5
						end else begin
							s_d.st = ST_TAIL;                             // R4
						end
					end
				end
			end
			ST_TAIL: begin
				if (rd_start) begin
					s_d.st  = ST_WAIT_K;
					s_d.req = 1'b1;
					s_d.cnt = BURST_LEN;
				end else if (launch_pos) begin
					s_d.oe = 1'b0;                                        // R4
					s_d.st = ST_IDLE;                                     // R2
				end
			end
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			s_q            <= '0;
			s_q.s1         <= PIN_RST;
			s_q.s2         <= PIN_RST;
			s_q.prev       <= PIN_RST;
			s_q.st         <= ST_IDLE;
			s_q.q          <= DATA_RST;
			s_q.oe         <= 1'b0;                                       // R13
			s_q.echo_n     <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign o_read_data         = s_q.q;
	assign o_read_data_oe      = s_q.oe;                                  // R2
	assign o_echo_strobe_pos   = s_q.echo_p;
	assign o_echo_strobe_neg   = s_q.echo_n;
	assign o_core_rd_req       = s_q.req;
	assign o_single_clock_mode = s_q.single;
endmodule

// File: testbench/ctrl_model.sv
// memory controller model driving the input and output clock pairs
`timescale 1ns/100ps
module ctrl_model (
	input  wire logic	i_single,
	output logic	o_kp,
	output logic	o_kn,
	output logic	o_cp,
	output logic	o_cn
);
	logic c = 1'b0;
	initial begin
		o_kp = 1'b0;
		#7;
		forever #80 o_kp = !o_kp;
	end
	// output pair skewed against the input pair for flight time
	initial begin
		#47;
		forever #80 c = !c;
	end
	assign o_kn = !o_kp;
	assign o_cp = i_single | c;
	assign o_cn = i_single | !c;
endmodule

// File: testbench/ddr_sram_read_port_chk.sv
// concurrent checks on the read port pins
`timescale 1ns/100ps
module ddr_sram_read_port_chk
	import sram_rd_pkg::*;
(
	input wire logic	i_sys_clk,
	input wire logic	i_arst_n,
	input wire logic	i_read_port_select_n,
	input wire logic	o_core_rd_req,
	input wire logic [sram_rd_pkg::DATA_W-1:0]	o_read_data,
	input wire logic	o_read_data_oe,
	input wire logic	o_echo_strobe_pos,
	input wire logic	o_echo_strobe_neg,
	input wire logic	o_single_clock_mode
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_arst_n);
	logic seen_q;
	logic e_q;
	logic [4:0] st_q;
	logic [5:0] ds_q;
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			seen_q <= 1'b0;
			e_q <= 1'b0;
			st_q <= 5'h00;
			ds_q <= 6'h00;
		end else begin
			seen_q <= seen_q | o_core_rd_req;
			e_q <= o_echo_strobe_pos;
			st_q <= (e_q != o_echo_strobe_pos) ? 5'h00 : st_q + 5'h01;
			ds_q <= !i_read_port_select_n ? 6'h00 : ds_q + 6'(ds_q != 6'h3F);
		end
	end
	first_read_a: assert property (!seen_q |-> !o_read_data_oe)
		else $error("data driven before any read");
	req_pulse_a: assert property (o_core_rd_req |=> !o_core_rd_req)
		else $error("read request longer than one cycle");
	req_select_a: assert property ($rose(o_core_rd_req) |-> ds_q < 6'd40)
		else $error("read started while deselected");
	release_edge_a: assert property ($fell(o_read_data_oe) |-> o_echo_strobe_pos)
		else $error("release off the output clock rise");
	launch_oe_a: assert property ($changed(o_read_data) |-> o_read_data_oe)
		else $error("data changed while released");
	echo_pair_a: assert property ($rose(o_echo_strobe_pos) |-> ##[0:1] $fell(o_echo_strobe_neg))
		else $error("echo clocks not complementary");
	echo_run_a: assert property (st_q < 5'd12)
		else $error("echo clock stopped");
	strap_hold_a: assert property (!$fell(o_single_clock_mode))
		else $error("clock mode strap changed");
	deselect_release_a: assert property (ds_q > 6'd55 |-> !o_read_data_oe)
		else $error("data driven while deselected");
endmodule

// File: testbench/ddr_sram_read_port_test.sv
// self-checking bench of the ddr sram read port
`timescale 1ns/100ps
module ddr_sram_read_port_test;
	import sram_rd_pkg::*;
	logic i_sys_clk = 1'b0;
	logic i_arst_n = 1'b0;
	logic i_read_port_select_n = 1'b1;
	logic i_dll_disable_n = 1'b1;
	logic i_core_valid = 1'b0;
	logic [DATA_W-1:0] i_core_data = DATA_RST;
	logic single = 1'b0;
	logic i_input_strobe_pos, i_input_strobe_neg, i_outbound_timing_pos, i_outbound_timing_neg;
	logic o_core_ready, o_core_rd_req, o_read_data_oe;
	logic o_echo_strobe_pos, o_echo_strobe_neg, o_single_clock_mode;
	logic [DATA_W-1:0] o_read_data, last_q;
	logic [15:0] lf = 16'hA687;
	logic [DATA_W-1:0] exp_q[$];
	int need, cyc, fail_count, tests_run;
	int age, words;
	logic [1:0] act, act_q = 2'h0;
	logic last_pos = 1'b0;
	assign act = single ? {i_input_strobe_neg, i_input_strobe_pos}
		: {i_outbound_timing_neg, i_outbound_timing_pos};

	initial forever #10 i_sys_clk = !i_sys_clk;

	ctrl_model i_ctrl (.i_single(single), .o_kp(i_input_strobe_pos), .o_kn(i_input_strobe_neg),
		.o_cp(i_outbound_timing_pos), .o_cn(i_outbound_timing_neg));
	ddr_sram_read_port i_dut (.i_sys_clk, .i_arst_n, .i_input_strobe_pos, .i_input_strobe_neg,
		.i_outbound_timing_pos, .i_outbound_timing_neg, .i_read_port_select_n,
		.i_dll_disable_n, .i_core_valid, .i_core_data, .o_core_ready, .o_core_rd_req,
		.o_read_data, .o_read_data_oe, .o_echo_strobe_pos, .o_echo_strobe_neg,
		.o_single_clock_mode);
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] nx(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] want);
		tests_run++;
		if (got !== want) begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, want);
		end
	endtask
	task automatic end_of_test;
		$display("mismatches %0d checks %0d", fail_count, tests_run);
		if (fail_count == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// core side: four words per request, expected order kept in a queue
	always @(posedge i_sys_clk) begin
		if (i_core_valid && o_core_ready) begin
			exp_q.push_back(i_core_data);
			need--;
			lf = nx(lf);
		end
		if (o_core_rd_req) need += 4;
		i_core_valid <= need > 0;
		i_core_data <= {2'h2, lf};
		cyc++;
		if (cyc == 6000) begin
			fail_count++;
			end_of_test;
		end
	end
	// every new word on the pins must be the next one pushed
	// a launch shows two edges after the active clock rise is seen, three with the dll off
	always @(posedge i_sys_clk) begin
		act_q <= act;
		if (|(act & ~act_q)) begin
			age <= 0;
			last_pos <= act[0] & ~act_q[0];
		end else begin
			age <= age + 1;
		end
		if (i_arst_n && o_read_data_oe === 1'b1 && o_read_data !== last_q) begin
			chk(o_read_data, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
			chk(DATA_W'(age), i_dll_disable_n ? 18'h00002 : 18'h00003);
			if (words % 4 == 0) chk(DATA_W'(last_pos), 18'h00001);
			words++;
		end
		last_q <= o_read_data;
	end
	task automatic run(input logic s, input logic d);
		int i;
		@(posedge i_sys_clk);
		i_arst_n <= 1'b0;
		single <= s;
		i_dll_disable_n <= d;
		repeat (8) @(posedge i_sys_clk);
		i_arst_n <= 1'b1;
		repeat (12) @(posedge i_sys_clk);
		chk(o_single_clock_mode, s);
		chk(o_read_data_oe, 1'b0);
		for (i = 0; i < 6; i++) begin
			@(negedge i_input_strobe_pos);
			@(posedge i_sys_clk) i_read_port_select_n <= 1'b0;
			// select held over two strobe rises gives a chained read
			if (i == 0 || lf[0]) @(negedge i_input_strobe_pos);
			@(negedge i_input_strobe_pos);
			@(posedge i_sys_clk) i_read_port_select_n <= 1'b1;
			repeat (5) @(negedge i_input_strobe_pos);
		end
		repeat (60) @(posedge i_sys_clk);
		chk(o_read_data_oe, 1'b0);
		chk(DATA_W'(exp_q.size()), DATA_RST);
	endtask
	initial begin
		run(1'b0, 1'b1);
		run(1'b0, 1'b0);
		run(1'b1, 1'b1);
		end_of_test;
	end
endmodule

bind ddr_sram_read_port ddr_sram_read_port_chk i_chk (.i_sys_clk, .i_arst_n,
	.i_read_port_select_n, .o_core_rd_req, .o_read_data, .o_read_data_oe,
	.o_echo_strobe_pos, .o_echo_strobe_neg, .o_single_clock_mode);
